// ==== design/cif_common_flags.sv ====
// common interrupt flag register, enable register and interrupt line
// assumes event inputs and register port come from logic on sys_clk
//
// How it works
// - event sets flag; enabled flag pulls intN low
// - intN low while enabled flag stays set
// - upper flags cleared by writing one
// - socket flag clears when socket register empties
// - address conflict event sets bit fifteen
// - port unreachable event sets bit fourteen
// - session close sets bit thirteen in PPPoE
// - fragment size event sets bit twelve
// - socket flag n mirrors socket n pending
// - enable register per flag, resets zero
`timescale 1ns/10ps
`include "cif_defines.svh"

module cif_common_flags
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [`CIF_ADDR_W-1:0] regAddr,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [1:0] regByteEn,
   input wire logic [`CIF_DATA_W-1:0] regWrData,
   output logic [`CIF_DATA_W-1:0] regRdData,
   input wire logic addrConflictEvt,
   input wire logic portUnreachEvt,
   input wire logic sessionCloseEvt,
   input wire logic pppoeModeActive,
   input wire logic fragSizeEvt,
   input wire logic [`CIF_NUM_SOCK-1:0] socketPending,
   output logic intN
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   cif_flag_if flagBus();
   cif_pkg::cif_sock_t sockFlags;
   cif_pkg::cif_sock_t next_sockFlags;
   cif_pkg::cif_word_t enable;
   cif_pkg::cif_word_t next_enable;
   cif_pkg::cif_word_t next_regRdData;
   cif_pkg::cif_word_t flagWord;
   cif_pkg::cif_upper_t setPulse;
   cif_pkg::cif_upper_t clearPulse;
   logic next_intN;
   logic hitFlags;
   logic hitEnable;
   logic anyActive;
   logic wrFlagsHi;
   logic wrEnable;
   logic rdFlags;
   logic rdEnable;

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   always_comb
   begin
      hitFlags = (regAddr == `CIF_OFF_FLAGS);
      hitEnable = (regAddr == `CIF_OFF_ENABLE);
   end

   // ----------------------------------------
   // write and read strobes
   // ----------------------------------------
   always_comb
   begin
      wrFlagsHi = regWrEn & hitFlags & regByteEn[`CIF_LANE_MSB];
      wrEnable = regWrEn & hitEnable;
      rdFlags = regRdEn & hitFlags;
      rdEnable = regRdEn & hitEnable;
   end

   // ----------------------------------------
   // upper byte events and clears
   // ----------------------------------------
   always_comb
   begin
      setPulse = '0;
      setPulse[`CIF_BIT_CONFLICT] = addrConflictEvt;
      setPulse[`CIF_BIT_UNREACH] = portUnreachEvt;
      setPulse[`CIF_BIT_SESSION] = sessionCloseEvt & pppoeModeActive;
      setPulse[`CIF_BIT_FRAG] = fragSizeEvt;
      clearPulse = '0;
      if (wrFlagsHi)
      begin
         // only ones clear; lower and reserved bits untouched
         clearPulse = regWrData[`CIF_UPPER_HI:`CIF_UPPER_LO];
      end
   end

   assign flagBus.setPulse = setPulse;
   assign flagBus.clearPulse = clearPulse;

   cif_upper_flags u_upper
   (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .flagBus(flagBus)
   );

   // ----------------------------------------
   // socket summary flags
   // ----------------------------------------
   always_comb
   begin
      // follow each socket register, set and auto clear
      next_sockFlags = socketPending;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         sockFlags <= `CIF_SOCK_RESET;
      end
      else
      begin
         sockFlags <= next_sockFlags;
      end
   end

   // ----------------------------------------
   // flag word
   // ----------------------------------------
   always_comb
   begin
      flagWord = '0; // reserved bits stay zero
      flagWord[`CIF_UPPER_HI:`CIF_UPPER_LO] = flagBus.flags;
      flagWord[`CIF_LOWER_HI:`CIF_LOWER_LO] = sockFlags;
   end

   // ----------------------------------------
   // enable register
   // ----------------------------------------
   always_comb
   begin
      next_enable = enable;
      if (wrEnable)
      begin
         if (regByteEn[`CIF_LANE_MSB])
         begin
            next_enable[`CIF_UPPER_HI:`CIF_UPPER_LO] =
               regWrData[`CIF_UPPER_HI:`CIF_UPPER_LO];
         end
         if (regByteEn[`CIF_LANE_LSB])
         begin
            next_enable[`CIF_LOWER_HI:`CIF_LOWER_LO] =
               regWrData[`CIF_LOWER_HI:`CIF_LOWER_LO];
         end
      end
      next_enable[`CIF_RSVD_HI:`CIF_RSVD_LO] = '0;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         enable <= `CIF_ENABLE_RESET;
      end
      else
      begin
         enable <= next_enable;
      end
   end

   // ----------------------------------------
   // read data
   // ----------------------------------------
   always_comb
   begin
      next_regRdData = regRdData;
      if (rdFlags)
      begin
         next_regRdData = flagWord;
      end
      else if (rdEnable)
      begin
         next_regRdData = enable;
      end
      else if (regRdEn)
      begin
         next_regRdData = '0;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         regRdData <= '0;
      end
      else
      begin
         regRdData <= next_regRdData;
      end
   end

   // ----------------------------------------
   // interrupt line
   // ----------------------------------------
   always_comb
   begin
      anyActive = |(flagWord & enable);
      next_intN = ~anyActive; // released only when no enabled flag set
   end

   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         intN <= `CIF_INTN_IDLE;
      end
      else
      begin
         intN <= next_intN;
      end
   end

endmodule : cif_common_flags

// ==== design/cif_defines.svh ====
// offsets, field positions and reset values of the common interrupt flags
// assumes inclusion by bare name from design files
`ifndef CIF_DEFINES_SVH
`define CIF_DEFINES_SVH

`define CIF_ADDR_W 10
`define CIF_DATA_W 16
`define CIF_OFF_FLAGS 10'h002
`define CIF_OFF_ENABLE 10'h004
`define CIF_FLAGS_RESET 16'h0000
`define CIF_ENABLE_RESET 16'h0000
`define CIF_UPPER_RESET 4'h0
`define CIF_SOCK_RESET 8'h00
`define CIF_INTN_IDLE 1'h1
`define CIF_UPPER_HI 15
`define CIF_UPPER_LO 12
`define CIF_RSVD_HI 11
`define CIF_RSVD_LO 8
`define CIF_LOWER_HI 7
`define CIF_LOWER_LO 0
`define CIF_NUM_UPPER 4
`define CIF_NUM_SOCK 8
`define CIF_BIT_CONFLICT 3
`define CIF_BIT_UNREACH 2
`define CIF_BIT_SESSION 1
`define CIF_BIT_FRAG 0
`define CIF_LANE_MSB 1
`define CIF_LANE_LSB 0

`endif

// ==== design/cif_pkg.sv ====
// types shared by the common interrupt flag block
// assumes cif_defines.svh is available on the include path
`include "cif_defines.svh"

package cif_pkg;
   typedef logic [`CIF_DATA_W-1:0] cif_word_t;
   typedef logic [`CIF_ADDR_W-1:0] cif_addr_t;
   typedef logic [`CIF_NUM_UPPER-1:0] cif_upper_t;
   typedef logic [`CIF_NUM_SOCK-1:0] cif_sock_t;
endpackage : cif_pkg

// ==== design/cif_flag_if.sv ====
// interface between the flag register top and the upper flag cells
// assumes one clock domain, sys_clk
`timescale 1ns/10ps

interface cif_flag_if;
   cif_pkg::cif_upper_t setPulse;
   cif_pkg::cif_upper_t clearPulse;
   cif_pkg::cif_upper_t flags;

   modport owner
   (
      output setPulse,
      output clearPulse,
      input flags
   );

   modport cells
   (
      input setPulse,
      input clearPulse,
      output flags
   );
endinterface : cif_flag_if

// ==== design/cif_upper_flags.sv ====
// sticky write-one-to-clear flag cells for the upper byte
// assumes set and clear pulses come from logic on sys_clk
`timescale 1ns/10ps
`include "cif_defines.svh"

module cif_upper_flags
(
   input wire logic sys_clk,
   input wire logic nrst,
   cif_flag_if.cells flagBus
);

   cif_pkg::cif_upper_t flagState;
   cif_pkg::cif_upper_t next_flagState;

   // ----------------------------------------
   // per-bit next value
   // ----------------------------------------
   genvar i;
   generate
      for (i = 0; i < `CIF_NUM_UPPER; i = i + 1)
      begin : g_cell
         always_comb
         begin
            // set wins over a coinciding clear
            next_flagState[i] = flagBus.setPulse[i] |
                                (flagState[i] & ~flagBus.clearPulse[i]);
         end
      end
   endgenerate

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
         flagState <= `CIF_UPPER_RESET;
      else
         flagState <= next_flagState;
   end

   assign flagBus.flags = flagState;

endmodule : cif_upper_flags

// ==== verif/cif_common_flags_props.sv ====
// assertions on the flag register ports
// assumes a bind onto cif_common_flags, one clock
`timescale 1ns/10ps

module cif_common_flags_props
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [9:0] regAddr,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [1:0] regByteEn,
   input wire logic [15:0] regWrData,
   input wire logic [15:0] regRdData,
   input wire logic addrConflictEvt,
   input wire logic portUnreachEvt,
   input wire logic sessionCloseEvt,
   input wire logic pppoeModeActive,
   input wire logic fragSizeEvt,
   input wire logic [7:0] socketPending,
   input wire logic intN
);
   logic [15:0] en;
   wire rdF = regRdEn && regAddr == 10'h002;
   wire rdE = regRdEn && regAddr == 10'h004;
   wire wrE = regWrEn && regAddr == 10'h004;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   // ---------------
   // enable mirror
   // ---------------
   always_ff @(posedge sys_clk)
      if (!nrst)
         en <= 16'h0000;
      else if (regWrEn && regAddr == 10'h004)
         en <= {regByteEn[1] ? {regWrData[15:12], 4'h0} : en[15:8],
            regByteEn[0] ? regWrData[7:0] : en[7:0]};
   a_rsvd_zero: assert property (rdF |=> regRdData[11:8] == 4'h0)
      else $error("reserved bits set");
   a_conflict_set: assert property (addrConflictEvt ##1 rdF |=> regRdData[15])
      else $error("conflict flag");
   a_session_set: assert property (sessionCloseEvt && pppoeModeActive ##1 rdF |=> regRdData[13])
      else $error("session flag");
   a_frag_set: assert property (fragSizeEvt ##1 rdF |=> regRdData[12])
      else $error("fragment flag");
   a_sock_mirror: assert property (rdF && $past(nrst) |=> regRdData[7:0] == $past(socketPending, 2))
      else $error("socket flags");
   a_enable_read: assert property (rdE |=> regRdData == $past(en))
      else $error("enable readback");
   a_int_event: assert property (addrConflictEvt && en[15] && !wrE |-> ##2 !intN)
      else $error("interrupt missing");
   a_int_sock: assert property (|(socketPending & en[7:0]) && !wrE |-> ##2 !intN)
      else $error("socket interrupt");
   cover property (rdF ##1 regRdData[15]);
   cover property ($fell(intN));
   cover property (regWrEn && regAddr == 10'h002 && regWrData[12]);
endmodule : cif_common_flags_props

bind cif_common_flags cif_common_flags_props chk_u (.*);

// ==== verif/cif_socket_model.sv ====
// summary of the per-socket event registers on the far side
// assumes raise and clear commands from the bench on sys_clk
`timescale 1ns/10ps

module cif_socket_model
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [7:0] raise,
   input wire logic [7:0] hostClear,
   output logic [7:0] socketPending
);
   // pending until the host empties the socket register
   always_ff @(posedge sys_clk)
      if (!nrst)
         socketPending <= 8'h00;
      else
         socketPending <= (socketPending & ~hostClear) | raise;
endmodule : cif_socket_model

// ==== verif/test_cif_common_flags.sv ====
// self-checking bench for the common interrupt flags
// assumes the checker bind and the socket model are compiled
`timescale 1ns/10ps

module test_cif_common_flags;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic regWrEn = 1'b0, regRdEn = 1'b0, pppoeModeActive = 1'b0, intN;
   logic [9:0] regAddr = 10'h000;
   logic [1:0] regByteEn = 2'h0;
   logic [15:0] regWrData = 16'h0000, regRdData;
   logic [3:0] evt = 4'h0;
   logic [7:0] raise = 8'h00, hostClear = 8'h00, socketPending;
   int n_fail = 0, samples_checked = 0;
   cif_common_flags dut_u (.*, .addrConflictEvt(evt[3]), .portUnreachEvt(evt[2]),
      .sessionCloseEvt(evt[1]), .fragSizeEvt(evt[0]));
   cif_socket_model host_u (.*);
   always #12.5 sys_clk = ~sys_clk;
   // ---------------
   // tasks
   // ---------------
   task automatic tick;
      @(posedge sys_clk) #1;
   endtask : tick
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [9:0] a, input logic [1:0] be, input logic [15:0] d);
      tick;
      regAddr = a;
      regByteEn = be;
      regWrData = d;
      regWrEn = 1'b1;
      tick;
      regWrEn = 1'b0;
   endtask : wr
   task automatic rdc(input logic [9:0] a, input logic [15:0] exp);
      tick;
      regAddr = a;
      regRdEn = 1'b1;
      tick;
      regRdEn = 1'b0;
      check(regRdData, exp);
   endtask : rdc
   task automatic t_events;
      wr(10'h004, 2'h3, 16'hFFFF);
      rdc(10'h004, 16'hF0FF);
      rdc(10'h00A, 16'h0000);
      pppoeModeActive = 1'b1;
      for (int k = 0; k < 4; k++)
      begin
         tick;
         evt[k] = 1'b1;
         tick;
         evt[k] = 1'b0;
         regAddr = 10'h002;
         regRdEn = 1'h1;
         tick;
         regRdEn = 1'h0;
         check(intN, 16'h0000);
         check(regRdData, 16'h1000 << k);
         wr(10'h002, 2'h3, 16'h00FF);
         rdc(10'h002, 16'h1000 << k);
         wr(10'h002, 2'h2, 16'h1000 << k);
         rdc(10'h002, 16'h0000);
         check(intN, 16'h0001);
      end
   endtask : t_events
   task automatic t_clash;
      tick;
      evt[0] = 1'b1;
      tick;
      regAddr = 10'h002;
      regByteEn = 2'h2;
      regWrData = 16'h1000;
      regWrEn = 1'b1;
      tick;
      evt[0] = 1'b0;
      regWrEn = 1'b0;
      rdc(10'h002, 16'h1000);
      wr(10'h002, 2'h2, 16'h1000);
      pppoeModeActive = 1'b0;
      evt[1] = 1'b1;
      tick;
      evt[1] = 1'b0;
      rdc(10'h002, 16'h0000);
   endtask : t_clash
   task automatic t_socket;
      for (int n = 0; n < 8; n++)
      begin
         raise[n] = 1'b1;
         tick;
         raise[n] = 1'b0;
         rdc(10'h002, 16'h0001 << n);
         check(intN, 16'h0000);
         hostClear[n] = 1'b1;
         tick;
         hostClear[n] = 1'b0;
         rdc(10'h002, 16'h0000);
      end
      wr(10'h004, 2'h1, 16'h0000);
      rdc(10'h004, 16'hF000);
      raise = 8'h81;
      tick;
      raise = 8'h00;
      rdc(10'h002, 16'h0081);
      check(intN, 16'h0001);
   endtask : t_socket
   task automatic t_reset;
      evt[3] = 1'h1;
      tick;
      evt[3] = 1'h0;
      tick;
      check(intN, 16'h0000);
      nrst = 1'h0;
      repeat (2) tick;
      nrst = 1'h1;
      check(intN, 16'h0001);
      rdc(10'h002, 16'h0000);
      rdc(10'h004, 16'h0000);
   endtask : t_reset
   task automatic results;
      if (n_fail == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : results
   initial
   begin
      #50000;
      n_fail++;
      results;
   end
   initial
   begin
      repeat (5) @(posedge sys_clk);
      #1 nrst = 1'b1;
      rdc(10'h002, 16'h0000);
      rdc(10'h004, 16'h0000);
      check(intN, 16'h0001);
      t_events;
      t_clash;
      t_socket;
      t_reset;
      results;
   end
endmodule : test_cif_common_flags
